/* File: pkg/efmp_defs.svh */
/*
  constants of the external master fifo port: widths, register offsets,
  field positions and reset values.
  assumes inclusion by bare name from the package and from every other file.
*/
`ifndef EFMP_DEFS_SVH
`define EFMP_DEFS_SVH

// data and queue geometry
`define EFMP_DW        16
`define EFMP_QDEPTH    16
`define EFMP_QAW       4
`define EFMP_QCW       5
`define EFMP_SYNC_W    18
`define EFMP_AW        8

// register byte offsets
`define EFMP_OFF_CTRL  8'h00
`define EFMP_OFF_STAT  8'h04
`define EFMP_OFF_MASK  8'h08
`define EFMP_OFF_TXD   8'h0c
`define EFMP_OFF_RXD   8'h10
`define EFMP_OFF_LVL   8'h14
`define EFMP_OFF_WMK   8'h18

// control fields
`define EFMP_CTRL_W      3
`define EFMP_CTRL_MODE   0
`define EFMP_CTRL_CLKOUT 1
`define EFMP_CTRL_W16    2
`define EFMP_CTRL_RST    3'h0

// status and mask fields
`define EFMP_ST_W      3
`define EFMP_ST_OVF    0
`define EFMP_ST_WMK    1
`define EFMP_ST_TXE    2
`define EFMP_ST_RST    3'h0

// watermark and level fields
`define EFMP_WMK_RST   5'h08
`define EFMP_LVL_RX_LO 16

`endif

/* File: pkg/efmp_pkg.sv */
/*
  types of the external master fifo port: state structs and port states.
  assumes efmp_defs.svh is on the include path.
*/
`include "efmp_defs.svh"

package efmp_pkg;

  // port data driver state
  typedef enum logic {PS_IDLE, PS_DRIVE} efmp_port_st_t;

  // queue storage and pointers
  typedef struct packed {
    logic [`EFMP_QDEPTH-1:0][`EFMP_DW-1:0] mem;
    logic [`EFMP_QAW-1:0]                  wptr;
    logic [`EFMP_QAW-1:0]                  rptr;
    logic [`EFMP_QCW-1:0]                  count;
  } efmp_q_st_t;

  // top level state
  typedef struct packed {
    logic [`EFMP_CTRL_W-1:0] ctrl;
    logic [`EFMP_ST_W-1:0]   stat;
    logic [`EFMP_ST_W-1:0]   mask;
    logic [`EFMP_QCW-1:0]    wmk;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    clk_prev;
    efmp_port_st_t           pst;
    logic [`EFMP_DW-1:0]     dout;
    logic                    doe;
    logic                    rreq;
    logic                    wflag;
    logic                    rden;
    logic                    irq;
  } efmp_top_st_t;

endpackage

/* File: pkg/efmp_q_if.sv */
/*
  push and pop carrier between the port core and one of its queues.
  assumes one owner (the queue) and one user (the core).
*/
`timescale 1ns/100ps
`default_nettype none
`include "efmp_defs.svh"

interface efmp_q_if;
  import efmp_pkg::*;
  logic                 push;
  logic [`EFMP_DW-1:0]  wdata;
  logic                 pop;
  logic [`EFMP_DW-1:0]  rdata;
  logic                 full;
  logic                 empty;
  logic [`EFMP_QCW-1:0] count;

  modport owner (input push, wdata, pop, output rdata, full, empty, count);
  modport user  (output push, wdata, pop, input rdata, full, empty, count);
endinterface

`default_nettype wire

/* File: hw/efmp_sync.sv */
/*
  two flop synchroniser for the port pins.
  assumes inputs asynchronous to clk; only stage two is read outside.
*/
`timescale 1ns/100ps
`default_nettype none
`include "efmp_defs.svh"

module efmp_sync
  import efmp_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // pins in, synchronised out
  input  wire logic [`EFMP_SYNC_W-1:0] din,
  output logic      [`EFMP_SYNC_W-1:0] dout
);

  logic [`EFMP_SYNC_W-1:0] s1_r;
  logic [`EFMP_SYNC_W-1:0] s2_r;

  // two stages, first read by second only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  assign dout = s2_r;

endmodule

`default_nettype wire

/* File: hw/efmp_queue.sv */
/*
  word queue used for both transmit and receive directions.
  assumes the user never relies on a push when full or a pop when empty;
  such requests are dropped here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "efmp_defs.svh"

module efmp_queue
  import efmp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // push and pop side
  efmp_q_if.owner   q
);

  efmp_q_st_t r_r;
  efmp_q_st_t r_nxt;
  logic       do_push;
  logic       do_pop;

  // head word and fill flags
  assign q.rdata = r_r.mem[r_r.rptr];
  assign q.count = r_r.count;
  assign q.empty = (r_r.count == '0);
  assign q.full  = (r_r.count == `EFMP_QCW'(`EFMP_QDEPTH));
  assign do_push = q.push & ~q.full;
  assign do_pop  = q.pop & ~q.empty;

  // pointer and count update
  always_comb begin
    r_nxt = r_r;
    if (do_push) begin
      r_nxt.mem[r_r.wptr] = q.wdata;
      r_nxt.wptr = r_r.wptr + `EFMP_QAW'(1);
    end
    if (do_pop) begin
      r_nxt.rptr = r_r.rptr + `EFMP_QAW'(1);
    end
    if (do_push & ~do_pop) begin
      r_nxt.count = r_r.count + `EFMP_QCW'(1);
    end else if (do_pop & ~do_push) begin
      r_nxt.count = r_r.count - `EFMP_QCW'(1);
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: hw/efmp_top.sv */
/*
  external master fifo port, slave side: the external media device drives
  the strobe clock and the direction pin, reads the transmit queue and
  writes the receive queue; software reaches both queues over apb.
  assumes port pins are asynchronous to ref_clk and the strobe clock is
  several times slower than ref_clk, so edges are found by sampling.
*/
// Notes on behaviour
// (R1) mode bit set, clock-out cleared: pins are inputs
// (R2) read request output flags transmit data ready
// (R3) master writes anytime; software drains faster
// (R4) write into full receive queue: overflow, drop
// (R5) rising strobe, direction high: drive next word
// (R6) read request falls one cycle after last read
// (R7) master never reads while read request low
// (R8) falling strobe, direction low: capture write word
// (R9) strobe edges move data and queue pointers
// (R10) software selects 8 or 16 bit width
// (R11) read request while one word is queued
// (R12) watermark flag when receive level reaches mark
// (R13) read enable output held high as slave
// (R14) reset empties queues, clears flags, drivers off
`timescale 1ns/100ps
`default_nettype none
`include "efmp_defs.svh"

module efmp_top
  import efmp_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`EFMP_AW-1:0]  paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // external port pins
  input  wire logic                 port_strobe_clock,
  input  wire logic                 transfer_direction,
  input  wire logic [`EFMP_DW-1:0]  port_data_bus_in,
  output logic      [`EFMP_DW-1:0]  port_data_bus_out,
  output logic                      port_data_bus_oe,
  output logic                      read_request_out,
  output logic                      rx_watermark_flag,
  output logic                      read_enable_out,
  // interrupt
  output logic                      irq
);

  efmp_top_st_t r_r;
  efmp_top_st_t r_nxt;

  efmp_q_if txq ();
  efmp_q_if rxq ();

  logic [`EFMP_SYNC_W-1:0] sync_q;
  logic                    s_clk;
  logic                    s_dir;
  logic [`EFMP_DW-1:0]     s_dat;
  logic                    port_on;
  logic                    w16;
  logic                    clk_rise;
  logic                    clk_fall;
  logic                    rd_edge;
  logic                    wr_edge;
  logic                    setup;
  logic                    wr_done;
  logic                    rd_done;
  logic                    ovf_evt;
  logic [`EFMP_QCW-1:0]    tx_cnt_nxt;
  logic [`EFMP_QCW-1:0]    rx_cnt_nxt;
  logic                    wflag_nxt;
  logic                    rreq_nxt;
  logic [`EFMP_ST_W-1:0]   st_set;
  logic [`EFMP_ST_W-1:0]   st_clr;

  // keep only the selected bus width, upper byte zero when narrow
  function automatic logic [`EFMP_DW-1:0] fit_width(
    input logic [`EFMP_DW-1:0] d,
    input logic                wide
  );
    fit_width = wide ? d : {8'h00, d[7:0]};
  endfunction

  // address equals the given register offset exactly
  function automatic logic addr_hit(
    input logic [`EFMP_AW-1:0] a,
    input logic [`EFMP_AW-1:0] off
  );
    addr_hit = (a == off);
  endfunction

  // pins cross into ref_clk before any use
  efmp_sync u_sync (
    .clk  (ref_clk),
    .rst  (sys_rst),
    .din  ({port_strobe_clock, transfer_direction, port_data_bus_in}),
    .dout (sync_q)
  );

  // transmit and receive queues
  efmp_queue u_txq (
    .clk (ref_clk),
    .rst (sys_rst),
    .q   (txq)
  );

  efmp_queue u_rxq (
    .clk (ref_clk),
    .rst (sys_rst),
    .q   (rxq)
  );

  // synchronised pins and mode decode
  assign s_clk   = sync_q[`EFMP_SYNC_W-1];
  assign s_dir   = sync_q[`EFMP_SYNC_W-2];
  assign s_dat   = sync_q[`EFMP_DW-1:0];
  assign port_on = r_r.ctrl[`EFMP_CTRL_MODE] & ~r_r.ctrl[`EFMP_CTRL_CLKOUT]; // see (R1)
  assign w16     = r_r.ctrl[`EFMP_CTRL_W16]; // see (R10)

  // strobe edge detection on the sampled clock
  assign clk_rise = s_clk & ~r_r.clk_prev; // see (R9)
  assign clk_fall = ~s_clk & r_r.clk_prev; // see (R9)

  // read on rising edge with direction high, only when data is queued
  assign rd_edge = port_on & clk_rise & s_dir & ~txq.empty; // see (R5) see (R7)
  // write on falling edge with direction low
  assign wr_edge = port_on & clk_fall & ~s_dir; // see (R8)
  assign ovf_evt = wr_edge & rxq.full; // see (R4)

  // apb phases: answer one cycle after setup
  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & r_r.pready & pwrite;
  assign rd_done = psel & penable & r_r.pready & ~pwrite;

  // queue strobes; master writes need no handshake
  assign txq.push  = wr_done & addr_hit(paddr, `EFMP_OFF_TXD) & ~txq.full;
  assign txq.wdata = fit_width(pwdata[`EFMP_DW-1:0], w16);
  assign txq.pop   = rd_edge; // see (R9)
  assign rxq.push  = wr_edge & ~rxq.full; // see (R3) see (R4) see (R9)
  assign rxq.wdata = fit_width(s_dat, w16); // see (R10)
  assign rxq.pop   = rd_done & addr_hit(paddr, `EFMP_OFF_RXD) & ~rxq.empty;

  // fill levels after this cycle's moves
  always_comb begin
    tx_cnt_nxt = txq.count;
    rx_cnt_nxt = rxq.count;
    if (txq.push & ~txq.pop) begin
      tx_cnt_nxt = txq.count + `EFMP_QCW'(1);
    end else if (txq.pop & ~txq.push) begin
      tx_cnt_nxt = txq.count - `EFMP_QCW'(1);
    end
    if (rxq.push & ~rxq.pop) begin
      rx_cnt_nxt = rxq.count + `EFMP_QCW'(1);
    end else if (rxq.pop & ~rxq.push) begin
      rx_cnt_nxt = rxq.count - `EFMP_QCW'(1);
    end
  end

  // read request and watermark levels
  assign rreq_nxt  = port_on & (tx_cnt_nxt != '0); // see (R2) see (R6) see (R11)
  assign wflag_nxt = (r_r.wmk != '0) & (rx_cnt_nxt >= r_r.wmk); // see (R12)

  // status events and write-one clears
  assign st_set = {r_r.rreq & ~rreq_nxt, wflag_nxt & ~r_r.wflag, ovf_evt};
  assign st_clr = (wr_done & addr_hit(paddr, `EFMP_OFF_STAT)) ?
                  pwdata[`EFMP_ST_W-1:0] : '0;

  // next state
  always_comb begin
    r_nxt          = r_r;
    r_nxt.clk_prev = s_clk;
    r_nxt.rreq     = rreq_nxt;
    r_nxt.wflag    = wflag_nxt;
    r_nxt.rden     = 1'b1; // see (R13)

    // status: a new event wins over a clear
    r_nxt.stat = (r_r.stat & ~st_clr) | st_set; // see (R4)
    r_nxt.irq  = |(r_nxt.stat & r_r.mask);

    // register writes
    if (wr_done) begin
      case (paddr)
        `EFMP_OFF_CTRL: begin
          r_nxt.ctrl = pwdata[`EFMP_CTRL_W-1:0]; // see (R1) see (R10)
        end
        `EFMP_OFF_MASK: begin
          r_nxt.mask = pwdata[`EFMP_ST_W-1:0];
        end
        `EFMP_OFF_WMK: begin
          r_nxt.wmk = pwdata[`EFMP_QCW-1:0];
        end
        default: begin
          r_nxt.ctrl = r_r.ctrl;
        end
      endcase
    end

    // apb answer: data and error prepared in setup, shown in access
    r_nxt.pready  = setup;
    r_nxt.pslverr = 1'b0;
    r_nxt.prdata  = '0;
    if (setup) begin
      case (paddr)
        `EFMP_OFF_CTRL: begin
          r_nxt.prdata[`EFMP_CTRL_W-1:0] = r_r.ctrl;
        end
        `EFMP_OFF_STAT: begin
          r_nxt.prdata[`EFMP_ST_W-1:0] = r_r.stat;
        end
        `EFMP_OFF_MASK: begin
          r_nxt.prdata[`EFMP_ST_W-1:0] = r_r.mask;
        end
        `EFMP_OFF_TXD: begin
          r_nxt.prdata = '0;
        end
        `EFMP_OFF_RXD: begin
          r_nxt.prdata[`EFMP_DW-1:0] = rxq.rdata;
        end
        `EFMP_OFF_LVL: begin
          r_nxt.prdata[`EFMP_QCW-1:0] = txq.count;
          r_nxt.prdata[`EFMP_LVL_RX_LO +: `EFMP_QCW] = rxq.count;
        end
        `EFMP_OFF_WMK: begin
          r_nxt.prdata[`EFMP_QCW-1:0] = r_r.wmk;
        end
        default: begin
          r_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // port data driver
    case (r_r.pst)
      PS_IDLE: begin
        if (rd_edge) begin
          r_nxt.pst  = PS_DRIVE;
          r_nxt.dout = fit_width(txq.rdata, w16); // see (R5) see (R10)
          r_nxt.doe  = 1'b1; // see (R5)
        end
      end
      PS_DRIVE: begin
        // hold the word through the falling edge for the master
        if (~port_on) begin
          r_nxt.pst = PS_IDLE;
          r_nxt.doe = 1'b0;
        end else if (rd_edge) begin
          r_nxt.dout = fit_width(txq.rdata, w16); // see (R5)
        end else if (clk_rise) begin
          r_nxt.pst = PS_IDLE;
          r_nxt.doe = 1'b0;
        end
      end
      default: begin
        r_nxt.pst = PS_IDLE;
        r_nxt.doe = 1'b0;
      end
    endcase
  end

  // state register; reset leaves drivers off and flags clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_r          <= '0; // see (R14)
      r_r.ctrl     <= `EFMP_CTRL_RST;
      r_r.stat     <= `EFMP_ST_RST; // see (R14)
      r_r.mask     <= `EFMP_ST_RST;
      r_r.wmk      <= `EFMP_WMK_RST;
      r_r.pst      <= PS_IDLE;
      r_r.rden     <= 1'b1; // see (R13)
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata            = r_r.prdata;
  assign pready            = r_r.pready;
  assign pslverr           = r_r.pslverr;
  assign port_data_bus_out = r_r.dout;
  assign port_data_bus_oe  = r_r.doe;
  assign read_request_out  = r_r.rreq; // see (R2)
  assign rx_watermark_flag = r_r.wflag; // see (R12)
  assign read_enable_out   = r_r.rden;
  assign irq               = r_r.irq;

endmodule

`default_nettype wire

/* File: tb/efmp_sva.sv */
/*
  assertions on the port pins and apb answer of efmp_top.
  assumes binding into efmp_top; sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
`include "efmp_defs.svh"

module efmp_sva
  import efmp_pkg::*;
(
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  // apb answer
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  // port pins
  input wire logic                port_strobe_clock,
  input wire logic                transfer_direction,
  input wire logic [`EFMP_DW-1:0] port_data_bus_out,
  input wire logic                port_data_bus_oe,
  input wire logic                read_request_out,
  input wire logic                rx_watermark_flag,
  input wire logic                read_enable_out,
  input wire logic                irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // outputs idle during reset and at the first edge after it
  a_reset_idle: assert property (disable iff (1'b0)
    sys_rst |=> !port_data_bus_oe && !read_request_out && !rx_watermark_flag && !irq)
    else $error("outputs not idle after reset");
  a_rden_high: assert property (read_enable_out)
    else $error("read enable low");
  // drivers turn on only inside a read strobe
  a_drive_on_read: assert property ($rose(port_data_bus_oe) |->
    transfer_direction && port_strobe_clock && $past(port_strobe_clock, 2))
    else $error("drive outside read strobe");
  a_drive_needs_req: assert property ($rose(port_data_bus_oe) |->
    $past(read_request_out))
    else $error("drive without request");
  // request drops with the drive of the last word
  a_req_drop_read: assert property ($fell(read_request_out) |->
    port_data_bus_oe && $past(port_strobe_clock, 2))
    else $error("request fell outside a read");
  a_hold_low_phase: assert property (port_data_bus_oe && !port_strobe_clock |=>
    port_data_bus_oe && $stable(port_data_bus_out))
    else $error("driven word moved in low phase");
  // apb answer shape
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

bind efmp_top efmp_sva i_efmp_sva (
  .ref_clk, .sys_rst, .psel, .penable, .pready, .pslverr, .port_strobe_clock,
  .transfer_direction, .port_data_bus_out, .port_data_bus_oe, .read_request_out,
  .rx_watermark_flag, .read_enable_out, .irq
);

`default_nettype wire

/* File: tb/efmp_master_model.sv */
/*
  external media device acting as port master: makes the strobe clock,
  the direction pin and the write data; strobe stands low between frames.
  assumes tasks are called one at a time from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
`include "efmp_defs.svh"

module efmp_master_model
  import efmp_pkg::*;
(
  // pins toward the port
  output logic                    port_strobe_clock,
  output logic                    transfer_direction,
  output logic [`EFMP_DW-1:0]     port_data_bus_in,
  // pins from the port
  input  wire logic [`EFMP_DW-1:0] port_data_bus_out,
  input  wire logic               port_data_bus_oe,
  input  wire logic               read_request_out
);
  localparam realtime half_ns = 62.5;

  logic [`EFMP_DW-1:0] drv_val;

  // wire level: port drivers win, else our own word
  assign port_data_bus_in = port_data_bus_oe ? port_data_bus_out : drv_val;

  initial begin
    port_strobe_clock  = 1'b0;
    transfer_direction = 1'b1;
    drv_val            = 16'h0000;
  end

  // one read strobe; word taken at the falling edge, refused without request
  task automatic do_read(output logic [`EFMP_DW-1:0] w, output logic ok);
    w  = '0;
    ok = 1'b0;
    if (read_request_out === 1'b1) begin
      transfer_direction <= 1'b1;
      #(half_ns);
      port_strobe_clock <= 1'b1;
      #(half_ns);
      w  = port_data_bus_out;
      ok = port_data_bus_oe;
      port_strobe_clock <= 1'b0;
      #(half_ns);
    end
  endtask

  // one write strobe, sent with no handshake
  task automatic do_write(input logic [`EFMP_DW-1:0] wd);
    transfer_direction <= 1'b0;
    drv_val            <= wd;
    #(half_ns);
    port_strobe_clock <= 1'b1;
    #(half_ns);
    port_strobe_clock <= 1'b0; // capture edge
    #(half_ns);
  endtask
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
/*
  self-checking bench of efmp_top: apb tasks reach the registers, the
  master model drives the port pins.
  assumes package, model and checker compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "efmp_defs.svh"

module tb_top
  import efmp_pkg::*;
;
  // clock, reset and apb
  logic                ref_clk;
  logic                sys_rst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [`EFMP_AW-1:0] paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  // port pins
  logic                port_strobe_clock;
  logic                transfer_direction;
  logic [`EFMP_DW-1:0] port_data_bus_in;
  logic [`EFMP_DW-1:0] port_data_bus_out;
  logic                port_data_bus_oe;
  logic                read_request_out;
  logic                rx_watermark_flag;
  logic                read_enable_out;
  logic                irq;
  int                  errors;
  int                  samples_checked;
  // flags: oe 0x10, request 0x08, watermark 0x04, irq 0x02, read enable 0x01
  wire  [31:0]         flags = {27'h0, port_data_bus_oe, read_request_out,
                                rx_watermark_flag, irq, read_enable_out};

  efmp_top i_efmp_top (
    .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_strobe_clock, .transfer_direction, .port_data_bus_in,
    .port_data_bus_out, .port_data_bus_oe, .read_request_out, .rx_watermark_flag,
    .read_enable_out, .irq
  );

  efmp_master_model i_efmp_master_model (
    .port_strobe_clock, .transfer_direction, .port_data_bus_in,
    .port_data_bus_out, .port_data_bus_oe, .read_request_out
  );

  always #5 ref_clk = ~ref_clk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
  endtask

  // main sequence
  initial begin
    logic [15:0] w;
    logic        ok;
    logic [31:0] r;
    logic        e;
    errors          = 0;
    samples_checked = 0;
    ref_clk         = 1'b0;
    sys_rst         = 1'b1;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0;
    repeat (5) @(posedge ref_clk);
    chk(flags, 32'h01);
    sys_rst <= 1'b0;
    rd(`EFMP_OFF_WMK, 32'h8);
    rd(`EFMP_OFF_LVL, 32'h0);
    // tx word while clock-out set keeps the port off
    wr(`EFMP_OFF_TXD, 32'h1234);
    wr(`EFMP_OFF_CTRL, 32'h3);
    settle();
    chk(flags, 32'h01);
    wr(`EFMP_OFF_CTRL, 32'h1);
    settle();
    chk(flags, 32'h09);
    i_efmp_master_model.do_read(w, ok);
    chk({15'h0, ok, w}, 32'h1_0034);
    chk(flags, 32'h11);
    rd(`EFMP_OFF_STAT, 32'h4);
    // 16-bit words read back to back
    wr(`EFMP_OFF_CTRL, 32'h5);
    for (int k = 0; k < 3; k++) begin
      wr(`EFMP_OFF_TXD, {16'hffff, 16'ha5c3 + 16'(k * 257)});
    end
    for (int k = 0; k < 3; k++) begin
      i_efmp_master_model.do_read(w, ok);
      chk({15'h0, ok, w}, {16'h1, 16'ha5c3 + 16'(k * 257)});
    end
    chk(flags, 32'h11);
    wr(`EFMP_OFF_STAT, 32'h7);
    wr(`EFMP_OFF_WMK, 32'h4);
    // writes past full: watermark, then overflow
    for (int k = 0; k < 17; k++) begin
      i_efmp_master_model.do_write(16'h5a00 + 16'(k));
      if (k == 2) begin
        chk(flags, 32'h01);
      end
      if (k == 3) begin
        chk(flags, 32'h05);
      end
    end
    rd(`EFMP_OFF_LVL, 32'h0010_0000);
    rd(`EFMP_OFF_STAT, 32'h3);
    chk(flags, 32'h05);
    wr(`EFMP_OFF_MASK, 32'h1);
    settle();
    chk(flags, 32'h07);
    wr(`EFMP_OFF_STAT, 32'h1);
    settle();
    chk(flags, 32'h05);
    rd(`EFMP_OFF_STAT, 32'h2);
    for (int k = 0; k < 16; k++) begin
      rd(`EFMP_OFF_RXD, 32'h5a00 + 32'(k));
    end
    // empty read shows the untouched head slot and pops nothing
    rd(`EFMP_OFF_RXD, 32'h5a00);
    rd(`EFMP_OFF_LVL, 32'h0);
    settle();
    chk(flags, 32'h01);
    // narrow mode keeps only the low byte of a captured word
    wr(`EFMP_OFF_CTRL, 32'h1);
    i_efmp_master_model.do_write(16'hbeef);
    rd(`EFMP_OFF_RXD, 32'hef);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    complete_run();
  end
endmodule

`default_nettype wire
